/* File: design/tlgb_pkg.sv */
// shared constants and state types of the telegram block handshake
package tlgb_pkg;
    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int BYTE_W = 8;
    localparam int LEN_W = 16;
    // ------------------------------------------------------------
    // image layout, byte offsets in bus order
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_SWITCH = 8'h00;
    localparam logic [7:0] OFS_COUNT_A = 8'h01;
    localparam logic [7:0] OFS_COUNT_B = 8'h02;
    localparam logic [7:0] OFS_LEN_LO = 8'h03;
    localparam logic [7:0] OFS_LEN_HI = 8'h04;
    localparam logic [7:0] OFS_PAYLOAD = 8'h05;
    localparam logic [7:0] HDR_LEN = 8'h05;
    localparam int AREA_MAX = 235;
    // ------------------------------------------------------------
    // counter values and reset values
    // ------------------------------------------------------------
    localparam logic [7:0] SEQ_WRAP = 8'hff;
    localparam logic [7:0] SEQ_FIRST = 8'h01;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [15:0] LEN_ZERO = 16'h0000;
    // ------------------------------------------------------------
    // state types
    // ------------------------------------------------------------
    typedef enum logic [5:0] {
        UP_IDLE = 6'h01,
        UP_LOAD = 6'h02,
        UP_FILL = 6'h04,
        UP_PUBLISH = 6'h08,
        UP_WAIT = 6'h10,
        UP_DRAIN = 6'h20
    } tlgb_up_state_type;
    typedef enum logic [2:0] {
        DN_IDLE = 3'h1,
        DN_SEND = 3'h2,
        DN_ACK = 3'h4
    } tlgb_dn_state_type;
endpackage : tlgb_pkg

/* File: design/tlgb_ram_if.sv */
// write and read port of one payload area
interface tlgb_ram_if;
    import tlgb_pkg::*;
    logic wrEn;
    logic [7:0] wrAddr;
    logic [7:0] wrData;
    logic [7:0] rdAddr;
    logic [7:0] rdData;
    modport mem (input wrEn, input wrAddr, input wrData, input rdAddr, output rdData);
    modport user (output wrEn, output wrAddr, output wrData, output rdAddr, input rdData);
endinterface : tlgb_ram_if

/* File: design/tlgb_image_ram.sv */
// payload area storage with one write port and one read port
module tlgb_image_ram (
    // clock
    input wire logic ref_clk,
    // port
    tlgb_ram_if.mem port
);
    import tlgb_pkg::*;
    logic [7:0] mem [AREA_MAX];
    // no reset: contents are only read after being written or zero filled
    always_ff @(posedge ref_clk) begin
        if (port.wrEn && port.wrAddr < 8'(AREA_MAX)) begin
            mem[port.wrAddr] <= port.wrData;
        end
    end
    assign port.rdData = (port.rdAddr < 8'(AREA_MAX)) ? mem[port.rdAddr] : BYTE_ZERO;
endmodule : tlgb_image_ram

/* File: design/tlgb_seq_wrap.sv */
// sequence counter that wraps from its top value to one, never to zero
module tlgb_seq_wrap (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // control
    input wire logic advance,
    // count
    output logic [7:0] count
);
    import tlgb_pkg::*;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            count <= BYTE_ZERO;
        end else if (advance) begin
            count <= (count == SEQ_WRAP) ? SEQ_FIRST : count + 8'h01;
        end
    end
    chk_seq_wrap_one: assert property (@(posedge ref_clk) disable iff (rst)
        advance && count == SEQ_WRAP |=> count == SEQ_FIRST)
        else $error("sequence counter did not wrap to one");
    chk_seq_never_zero: assert property (@(posedge ref_clk) disable iff (rst)
        advance |=> count != BYTE_ZERO)
        else $error("sequence counter advanced to zero");
endmodule : tlgb_seq_wrap

/* File: design/tlgb_telegram_block_handshake.sv */
// counter-handshaked telegram framer between serial side and fieldbus images
// ------------------------------------------------------------
// How it works
// - long incoming telegrams go out as successive blocks in the same fields
// - first block: leading data, whole length, then sequence advance
// - ack equals sequence: next part, length minus area, advance again
// - image order: switch byte, sequence then ack (upstream image) or ack then sequence (downstream image), length low then high, data
// - payload area is image length minus five header bytes
// - downstream bytes beyond the indicated length are ignored
// - both directions run independently; done when counters match
// - unacknowledged mode truncates incoming telegrams, reports full length
// - unacknowledged mode drops oversized downstream telegrams entirely
// - unacknowledged mode advances sequence without waiting for ack
// - unacknowledged mode lets a new telegram overwrite an unread one
// - unused payload bytes are zeroed before the sequence advance
// - sequence counter wraps 255 to 1, zero only after reset
// - reset zeroes upstream sequence, downstream ack and upstream length
// ------------------------------------------------------------
module tlgb_telegram_block_handshake (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // configuration, from gateway logic on ref_clk
    input wire logic ackMode,
    input wire logic [tlgb_pkg::BYTE_W-1:0] inImageLen,
    input wire logic [tlgb_pkg::BYTE_W-1:0] outImageLen,
    // incoming telegram from serial side
    input wire logic rxValid,
    input wire logic [tlgb_pkg::BYTE_W-1:0] rxData,
    input wire logic [tlgb_pkg::LEN_W-1:0] rxLen,
    output logic rxReady,
    // outgoing telegram to serial side
    output logic txValid,
    output logic [tlgb_pkg::BYTE_W-1:0] txData,
    output logic txLast,
    input wire logic txReady,
    // upstream image read by the fieldbus
    input wire logic [tlgb_pkg::BYTE_W-1:0] swInStatus,
    input wire logic [tlgb_pkg::BYTE_W-1:0] fbRdAddr,
    output logic [tlgb_pkg::BYTE_W-1:0] fbRdData,
    // downstream image written by the fieldbus
    input wire logic fbWrEn,
    input wire logic [tlgb_pkg::BYTE_W-1:0] fbWrAddr,
    input wire logic [tlgb_pkg::BYTE_W-1:0] fbWrData,
    input wire logic fbCycleDone,
    output logic [tlgb_pkg::BYTE_W-1:0] swOutCtrl
);
    import tlgb_pkg::*;

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    tlgb_up_state_type upState_reg;
    tlgb_dn_state_type dnState_reg;
    logic [7:0] nIn, nOut, upSeq;
    logic [7:0] upIdx_reg, upBlk_reg, upAck_reg;
    logic [15:0] upRem_reg, upLen_reg, upDrain_reg;
    logic rxReady_reg, upTake, upStart, upResume;
    logic [7:0] dnSeq_reg, dnAck_reg, dnIdx_reg, dnCnt_reg, swOutCtrl_reg;
    logic [15:0] dnLen_reg;
    logic dnFinal_reg, dnGo, txValid_reg, txLast_reg;
    logic [7:0] txData_reg, fbRdData_reg;

    tlgb_ram_if upPort ();
    tlgb_ram_if dnPort ();

    // bytes that fit into the area for a given remaining length
    function automatic logic [7:0] blockSize(input logic [15:0] rem, input logic [7:0] area);
        blockSize = (rem > {8'h00, area}) ? area : rem[7:0];
    endfunction : blockSize

    // ------------------------------------------------------------
    // area sizes and storage
    // ------------------------------------------------------------
    assign nIn = inImageLen - HDR_LEN;
    assign nOut = outImageLen - HDR_LEN;

    tlgb_image_ram upRam (
        .ref_clk(ref_clk),
        .port(upPort.mem)
    );
    tlgb_image_ram dnRam (
        .ref_clk(ref_clk),
        .port(dnPort.mem)
    );
    tlgb_seq_wrap upSeqCnt (
        .ref_clk(ref_clk),
        .rst(rst),
        .advance(upState_reg == UP_PUBLISH),
        .count(upSeq)
    );

    // ------------------------------------------------------------
    // upstream: serial telegram into blocks
    // ------------------------------------------------------------
    assign upTake = rxValid && rxReady_reg;
    // unacknowledged mode overwrites whatever the master has not read yet
    assign upStart = rxValid && (!ackMode || upAck_reg == upSeq);
    assign upResume = upAck_reg == upSeq;
    assign upPort.wrEn = (upState_reg == UP_LOAD && upTake) || upState_reg == UP_FILL;
    assign upPort.wrAddr = upIdx_reg;
    assign upPort.wrData = (upState_reg == UP_FILL) ? BYTE_ZERO : rxData;
    assign upPort.rdAddr = fbRdAddr - OFS_PAYLOAD;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            upState_reg <= UP_IDLE;
            upIdx_reg <= BYTE_ZERO;
            upBlk_reg <= BYTE_ZERO;
            upRem_reg <= LEN_ZERO;
            upLen_reg <= LEN_ZERO;
            upDrain_reg <= LEN_ZERO;
        end else begin
            case (upState_reg)
                UP_IDLE: begin
                    if (upStart) begin
                        upRem_reg <= rxLen;
                        upBlk_reg <= blockSize(rxLen, nIn);
                        upIdx_reg <= BYTE_ZERO;
                        upState_reg <= UP_LOAD;
                    end
                end
                UP_LOAD: begin
                    if (upIdx_reg == upBlk_reg) begin
                        upState_reg <= UP_FILL;
                    end else if (upTake) begin
                        upIdx_reg <= upIdx_reg + 8'h01;
                    end
                end
                UP_FILL: begin
                    if (upIdx_reg >= nIn) begin
                        upState_reg <= UP_PUBLISH;
                    end else begin
                        upIdx_reg <= upIdx_reg + 8'h01;
                    end
                end
                UP_PUBLISH: begin
                    // length lands on the same edge as the count, after the payload
                    upLen_reg <= upRem_reg;
                    if (upRem_reg > {8'h00, nIn} && ackMode) begin
                        upRem_reg <= upRem_reg - {8'h00, nIn};
                        upState_reg <= UP_WAIT;
                    end else if (upRem_reg > {8'h00, nIn}) begin
                        upDrain_reg <= upRem_reg - {8'h00, nIn};
                        upState_reg <= UP_DRAIN;
                    end else begin
                        upState_reg <= UP_IDLE;
                    end
                end
                UP_WAIT: begin
                    if (upResume) begin
                        upBlk_reg <= blockSize(upRem_reg, nIn);
                        upIdx_reg <= BYTE_ZERO;
                        upState_reg <= UP_LOAD;
                    end
                end
                UP_DRAIN: begin
                    if (upDrain_reg == LEN_ZERO) begin
                        upState_reg <= UP_IDLE;
                    end else if (upTake) begin
                        upDrain_reg <= upDrain_reg - 16'h0001;
                    end
                end
                default: begin
                    upState_reg <= UP_IDLE;
                end
            endcase
        end
    end

    // registered ready: predicted one cycle ahead so it never overshoots a block
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rxReady_reg <= 1'b0;
        end else begin
            case (upState_reg)
                UP_IDLE: rxReady_reg <= upStart && blockSize(rxLen, nIn) != BYTE_ZERO;
                UP_WAIT: rxReady_reg <= upResume && blockSize(upRem_reg, nIn) != BYTE_ZERO;
                UP_LOAD: rxReady_reg <= ({1'b0, upIdx_reg} + {8'h00, upTake}) < {1'b0, upBlk_reg};
                UP_PUBLISH: rxReady_reg <= !ackMode && upRem_reg > {8'h00, nIn};
                UP_DRAIN: rxReady_reg <= (upDrain_reg - {15'h0000, upTake}) != LEN_ZERO;
                default: rxReady_reg <= 1'b0;
            endcase
        end
    end

    // ------------------------------------------------------------
    // downstream image header, written by the fieldbus
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            swOutCtrl_reg <= BYTE_ZERO;
            upAck_reg <= BYTE_ZERO;
            dnSeq_reg <= BYTE_ZERO;
            dnLen_reg <= LEN_ZERO;
        end else if (fbWrEn) begin
            case (fbWrAddr)
                OFS_SWITCH: swOutCtrl_reg <= fbWrData;
                OFS_COUNT_A: upAck_reg <= fbWrData;
                OFS_COUNT_B: dnSeq_reg <= fbWrData;
                OFS_LEN_LO: dnLen_reg[7:0] <= fbWrData;
                OFS_LEN_HI: dnLen_reg[15:8] <= fbWrData;
                default: ;
            endcase
        end
    end
    assign dnPort.wrEn = fbWrEn && fbWrAddr >= OFS_PAYLOAD;
    assign dnPort.wrAddr = fbWrAddr - OFS_PAYLOAD;
    assign dnPort.wrData = fbWrData;
    assign dnPort.rdAddr = dnIdx_reg;

    // ------------------------------------------------------------
    // downstream: image blocks out to the serial side
    // ------------------------------------------------------------
    // a new count is only looked at once a whole fieldbus cycle has landed
    assign dnGo = fbCycleDone && dnSeq_reg != dnAck_reg;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            dnState_reg <= DN_IDLE;
            dnAck_reg <= BYTE_ZERO;
            dnIdx_reg <= BYTE_ZERO;
            dnCnt_reg <= BYTE_ZERO;
            dnFinal_reg <= 1'b0;
            txValid_reg <= 1'b0;
            txData_reg <= BYTE_ZERO;
            txLast_reg <= 1'b0;
        end else begin
            case (dnState_reg)
                DN_IDLE: begin
                    if (dnGo && !ackMode && dnLen_reg > {8'h00, nOut}) begin
                        dnState_reg <= DN_ACK;
                    end else if (dnGo) begin
                        dnIdx_reg <= BYTE_ZERO;
                        dnCnt_reg <= blockSize(dnLen_reg, nOut);
                        dnFinal_reg <= dnLen_reg <= {8'h00, nOut};
                        dnState_reg <= DN_SEND;
                    end
                end
                DN_SEND: begin
                    if (!txValid_reg || txReady) begin
                        if (dnIdx_reg < dnCnt_reg) begin
                            txValid_reg <= 1'b1;
                            txData_reg <= dnPort.rdData;
                            txLast_reg <= dnFinal_reg && dnIdx_reg == dnCnt_reg - 8'h01;
                            dnIdx_reg <= dnIdx_reg + 8'h01;
                        end else begin
                            txValid_reg <= 1'b0;
                            txLast_reg <= 1'b0;
                            dnState_reg <= DN_ACK;
                        end
                    end
                end
                DN_ACK: begin
                    dnAck_reg <= dnSeq_reg;
                    dnState_reg <= DN_IDLE;
                end
                default: begin
                    dnState_reg <= DN_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // upstream image read port
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            fbRdData_reg <= BYTE_ZERO;
        end else begin
            case (fbRdAddr)
                OFS_SWITCH: fbRdData_reg <= swInStatus;
                OFS_COUNT_A: fbRdData_reg <= upSeq;
                OFS_COUNT_B: fbRdData_reg <= dnAck_reg;
                OFS_LEN_LO: fbRdData_reg <= upLen_reg[7:0];
                OFS_LEN_HI: fbRdData_reg <= upLen_reg[15:8];
                default: fbRdData_reg <= (fbRdAddr < inImageLen) ? upPort.rdData : BYTE_ZERO;
            endcase
        end
    end

    assign rxReady = rxReady_reg;
    assign txValid = txValid_reg;
    assign txData = txData_reg;
    assign txLast = txLast_reg;
    assign fbRdData = fbRdData_reg;
    assign swOutCtrl = swOutCtrl_reg;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    sequence longDownStart;
        dnState_reg == DN_IDLE && dnGo && !ackMode && dnLen_reg > {8'h00, nOut};
    endsequence
    sequence longUpPublish;
        upState_reg == UP_PUBLISH && ackMode && upRem_reg > {8'h00, nIn};
    endsequence

    chk_len_with_seq: assert property ($changed(upLen_reg) |-> $changed(upSeq))
        else $error("upstream length changed without a sequence advance");
    chk_block_wait: assert property (longUpPublish |=>
        upState_reg == UP_WAIT && upRem_reg == $past(upRem_reg) - {8'h00, nIn})
        else $error("blocked transfer did not reduce remaining length");
    chk_ack_gates: assert property (ackMode && $rose(upState_reg == UP_LOAD) |->
        $past(upAck_reg) == $past(upSeq))
        else $error("block loaded before acknowledge matched");
    chk_zero_fill: assert property (upState_reg == UP_FILL && upIdx_reg < nIn |->
        upPort.wrEn && upPort.wrData == BYTE_ZERO)
        else $error("unused payload byte not cleared");
    chk_full_len: assert property (upState_reg == UP_PUBLISH |=>
        upLen_reg == $past(upRem_reg) && upSeq != $past(upSeq))
        else $error("published length or sequence wrong");
    chk_drop_long: assert property (longDownStart |=>
        dnState_reg == DN_ACK && !txValid_reg ##1 dnAck_reg == $past(dnSeq_reg))
        else $error("oversized downstream telegram not dropped");
    chk_ack_done: assert property (dnState_reg == DN_ACK |=>
        dnAck_reg == $past(dnSeq_reg) && dnState_reg == DN_IDLE)
        else $error("downstream acknowledge not equalised");
    chk_no_overrun: assert property (txValid_reg && txLast_reg && txReady |=>
        !txValid_reg)
        else $error("bytes sent past the indicated length");
endmodule : tlgb_telegram_block_handshake

/* File: sim/tlgb_master_model.sv */
// fieldbus master model: polls the upstream image, acks blocks, writes downstream images
module tlgb_master_model (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // configuration
    input wire logic ackMode,
    input wire logic [7:0] inImageLen,
    // upstream image
    output logic [7:0] fbRdAddr,
    input wire logic [7:0] fbRdData,
    // downstream image
    output logic fbWrEn,
    output logic [7:0] fbWrAddr,
    output logic [7:0] fbWrData,
    output logic fbCycleDone,
    // observations
    output logic obsValid,
    output logic [7:0] obsByte,
    output logic [7:0] seenAck
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] seq;
    logic [7:0] lastSeq;
    logic [7:0] d;
    logic dnPend;
    logic [7:0] dnImg[$];
    int ackDelay = 3;
    task automatic queue_down(input logic [7:0] img[$]);
        dnImg = img;
        dnPend = 1'b1;
    endtask : queue_down
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(negedge ref_clk) fbRdAddr = a;
        @(negedge ref_clk) v = fbRdData;
    endtask : rd
    task automatic note(input logic [7:0] v);
        obsByte = v;
        obsValid = 1'b1;
        @(negedge ref_clk) obsValid = 1'b0;
        // one idle edge so back-to-back notes never re-raise the strobe at once
        @(negedge ref_clk);
    endtask : note
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(negedge ref_clk) fbWrEn = 1'b1;
        fbWrAddr = a;
        fbWrData = v;
    endtask : wr
    initial begin
        {fbRdAddr, fbWrEn, fbWrAddr, fbWrData, fbCycleDone} = '0;
        {obsValid, obsByte, seenAck, dnPend} = '0;
        lastSeq = 8'h00;
        wait (rst === 1'b0);
        forever begin
            rd(8'h02, seenAck);
            rd(8'h01, seq);
            if (seq !== lastSeq && seq !== 8'h00) begin
                lastSeq = seq;
                // whole area is read, so zero fill beyond the length is seen too
                rd(8'h00, d);
                note(d);
                note(seq);
                for (int i = 3; i < int'(inImageLen); i++) begin
                    rd(8'(i), d);
                    note(d);
                end
                if (ackMode) begin
                    repeat (ackDelay) @(negedge ref_clk);
                    wr(8'h01, seq);
                    @(negedge ref_clk) fbWrEn = 1'b0;
                end
            end
            if (dnPend) begin
                // byte 1 is skipped: it carries the upstream ack
                for (int i = 0; i < dnImg.size(); i++) begin
                    if (i != 1) wr(8'(i), dnImg[i]);
                end
                @(negedge ref_clk) fbWrEn = 1'b0;
                fbCycleDone = 1'b1;
                @(negedge ref_clk) fbCycleDone = 1'b0;
                dnPend = 1'b0;
            end
        end
    end
endmodule : tlgb_master_model

/* File: sim/tlgb_telegram_block_handshake_tb.sv */
// self-checking bench of the telegram block handshake
`define CHK(nm, e, a) begin checked++; if ((a) !== (e)) begin n_mismatch++; \
    $display("[ERR] %s exp %h got %h", nm, e, a); end end
module tlgb_telegram_block_handshake_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import tlgb_pkg::*;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic ackMode = 1'b1;
    logic [7:0] inImageLen = 8'h0a;
    logic [7:0] outImageLen = 8'h0a;
    logic rxValid = 1'b0;
    logic [7:0] rxData = 8'h00;
    logic [15:0] rxLen = 16'h0000;
    logic txReady = 1'b0;
    logic [7:0] swInStatus = 8'h00;
    logic rxReady, txValid, txLast, fbWrEn, fbCycleDone, obsValid;
    logic [7:0] txData, fbRdAddr, fbRdData, fbWrAddr, fbWrData, swOutCtrl, obsByte, seenAck;
    logic [7:0] upQ[$];
    logic [8:0] txQ[$];
    logic [7:0] upSeq = 8'h00;
    logic [7:0] dnSeq = 8'h00;
    logic [8:0] upExp;
    logic [9:0] txExp;
    int n_mismatch = 0;
    int checked = 0;
    int cyc = 0;
    tlgb_telegram_block_handshake uut (.ref_clk(ref_clk), .rst(rst), .ackMode(ackMode),
        .inImageLen(inImageLen), .outImageLen(outImageLen), .rxValid(rxValid),
        .rxData(rxData), .rxLen(rxLen), .rxReady(rxReady), .txValid(txValid),
        .txData(txData), .txLast(txLast), .txReady(txReady), .swInStatus(swInStatus),
        .fbRdAddr(fbRdAddr), .fbRdData(fbRdData), .fbWrEn(fbWrEn), .fbWrAddr(fbWrAddr),
        .fbWrData(fbWrData), .fbCycleDone(fbCycleDone), .swOutCtrl(swOutCtrl));
    tlgb_master_model mdl (.ref_clk(ref_clk), .rst(rst), .ackMode(ackMode),
        .inImageLen(inImageLen), .fbRdAddr(fbRdAddr), .fbRdData(fbRdData),
        .fbWrEn(fbWrEn), .fbWrAddr(fbWrAddr), .fbWrData(fbWrData),
        .fbCycleDone(fbCycleDone), .obsValid(obsValid), .obsByte(obsByte),
        .seenAck(seenAck));
    initial begin
        forever #10 ref_clk = ~ref_clk;
    end
    task automatic end_of_test;
        $display("checked %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : end_of_test
    // sink stalls at random so tx outputs must hold
    always @(negedge ref_clk) txReady <= ($urandom_range(3) != 0);
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 60000) begin
            n_mismatch++;
            end_of_test();
        end
    end
    always @(posedge ref_clk) begin
        if (obsValid === 1'b1) begin
            upExp = (upQ.size() != 0) ? {1'b0, upQ.pop_front()} : 9'h100;
            `CHK("upstream byte", upExp, {1'b0, obsByte})
        end
        if (txValid === 1'b1 && txReady === 1'b1) begin
            txExp = (txQ.size() != 0) ? {1'b0, txQ.pop_front()} : 10'h200;
            `CHK("tx byte", txExp, {1'b0, txLast, txData})
        end
    end
    task automatic send_up(input int len);
        logic [7:0] b[$];
        logic [15:0] r;
        int rem, k, i;
        for (i = 0; i < len; i++) b.push_back(8'($urandom));
        rem = len;
        k = 0;
        do begin
            upSeq = (upSeq == 8'hff) ? 8'h01 : upSeq + 8'h01;
            r = 16'(rem);
            upQ.push_back(swInStatus);
            upQ.push_back(upSeq);
            upQ.push_back(r[7:0]);
            upQ.push_back(r[15:8]);
            for (i = 0; i < int'(inImageLen) - 5; i++) begin
                upQ.push_back((k + i < len) ? b[k + i] : 8'h00);
            end
            rem -= int'(inImageLen) - 5;
            k += int'(inImageLen) - 5;
        end while (ackMode && rem > 0);
        @(negedge ref_clk) rxValid = 1'b1;
        rxLen = 16'(len);
        rxData = b[0];
        i = 0;
        while (i < len) begin
            @(posedge ref_clk) if (rxReady === 1'b1) i++;
            @(negedge ref_clk) if (i < len) rxData = b[i];
            else rxValid = 1'b0;
        end
    endtask : send_up
    task automatic send_down(input int len);
        logic [7:0] img[$];
        logic [15:0] r;
        logic [7:0] ctl;
        ctl = 8'($urandom);
        dnSeq = dnSeq + 8'h01;
        r = 16'(len);
        img = '{ctl, 8'h00, dnSeq, r[7:0], r[15:8]};
        for (int i = 0; i < int'(outImageLen) - 5; i++) begin
            img.push_back(8'($urandom));
            // a blocked image sends its whole area, last flag only on a fitting one
            if (i < len && (ackMode || len <= int'(outImageLen) - 5)) begin
                txQ.push_back({i == len - 1, img[i + 5]});
            end
        end
        mdl.queue_down(img);
        while (seenAck !== dnSeq) @(negedge ref_clk);
        `CHK("tx remaining", 32'd0, txQ.size())
        `CHK("switch out", ctl, swOutCtrl)
    endtask : send_down
    task automatic close_test(input int t);
        while (upQ.size() != 0) @(negedge ref_clk);
        repeat (20) @(negedge ref_clk);
        $display("test %0d end", t);
    endtask : close_test
    initial begin
        void'($urandom(32'h1f64));
        repeat (5) @(negedge ref_clk);
        rst = 1'b0;
        repeat (30) @(negedge ref_clk);
        `CHK("downstream ack", 8'h00, seenAck)
        `CHK("switch out", 8'h00, swOutCtrl)
        `CHK("rx ready", 1'b0, rxReady)
        close_test(0);
        swInStatus = 8'($urandom);
        send_up(9);
        send_up(5);
        send_up(3);
        send_down(6);
        send_down(1);
        close_test(1);
        fork
            send_up(9);
            send_down(2);
        join
        close_test(2);
        inImageLen = 8'h08;
        outImageLen = 8'h08;
        send_up(7);
        send_down(3);
        close_test(3);
        while (upSeq != 8'hff) send_up(1);
        send_up(2);
        close_test(4);
        ackMode = 1'b0;
        inImageLen = 8'h0a;
        outImageLen = 8'h0a;
        send_up(9);
        close_test(5);
        send_up(4);
        send_down(7);
        send_down(3);
        close_test(6);
        end_of_test();
    end
endmodule : tlgb_telegram_block_handshake_tb
